//--- rtl/spi_port_cfg.svh
// Constants for the serial port pin-role and select logic.
`ifndef SPI_PORT_CFG_SVH
`define SPI_PORT_CFG_SVH

`define SEL_THREE_WIRE     2'h0
`define SEL_FOUR_WIRE_IN   2'h1
`define SEL_OUT_BIT        1
`define SEL_LEVEL_BIT      0
`define SEL_MODE_RESET     2'h1
`define MASTER_EN_RESET    1'h0
`define PORT_EN_RESET      1'h0
`define BYTE_BITS          8
`define SCK_HALF_CYCLES    4
`define SYNC_NSS           0
`define SYNC_MISO          1
`define SYNC_DONE          2
`define SYNC_COUNT         3

`endif

//--- rtl/spi_port_pkg.sv
// Types shared by the serial port pin-role and select logic.
package spi_port_pkg;

  typedef enum logic [1:0] {
    M_IDLE,
    M_LOW,
    M_HIGH
  } master_state_t;

  typedef logic [1:0] select_mode_t;

endpackage

//--- rtl/spi_sync.sv
// Two-stage synchroniser for levels entering the core clock domain.
`timescale 1ns/10ps
module spi_sync #(
  parameter int WIDTH = 1
) (
  // Clock and reset
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  // Data
  input  wire logic [WIDTH-1:0] d_i,
  output wire logic [WIDTH-1:0] q_o
);
  logic [WIDTH-1:0] stage1;
  logic [WIDTH-1:0] stage2;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      stage1 <= '0;
      stage2 <= '0;
    end else begin
      stage1 <= d_i;
      stage2 <= stage1;
    end
  end

  assign q_o = stage2;
endmodule // spi_sync

//--- rtl/spi_link_shifter.sv
// Slave-side shifter clocked by the serial clock from the external master.
`timescale 1ns/10ps
`include "spi_port_cfg.svh"
module spi_link_shifter #(
  parameter int WIDTH = `BYTE_BITS,
  parameter int CW    = $clog2(WIDTH)
) (
  // Link clock and clears
  input  wire logic             sck_i,
  input  wire logic             hold_i,
  input  wire logic             restart_i,
  // Serial data
  input  wire logic             mosi_i,
  // Toward the core domain
  output logic      [WIDTH-1:0] rx_byte_o,
  output logic                  done_tgl_o,
  output logic      [CW-1:0]    out_idx_o
);
  logic [CW-1:0]    bit_cnt;
  logic [WIDTH-2:0] shift_in;

  // Deselecting the device restarts the bit count, so a partial byte is dropped.
  always_ff @(posedge sck_i or posedge restart_i) begin
    if (restart_i) begin
      bit_cnt  <= '0;
      shift_in <= '0;
    end else if (bit_cnt == CW'(WIDTH - 1)) begin
      bit_cnt  <= '0;
    end else begin
      bit_cnt  <= bit_cnt + CW'(1);
      shift_in <= {shift_in[WIDTH-3:0], mosi_i};
    end
  end

  always_ff @(posedge sck_i or posedge hold_i) begin
    if (hold_i) begin
      rx_byte_o  <= '0;
      done_tgl_o <= 1'h0;
    end else if (!restart_i && bit_cnt == CW'(WIDTH - 1)) begin
      rx_byte_o  <= {shift_in, mosi_i};
      done_tgl_o <= ~done_tgl_o;
    end
  end

  // Outgoing bit advances on the falling edge, ready for the next rising edge.
  always_ff @(negedge sck_i or posedge restart_i) begin
    if (restart_i) begin
      out_idx_o <= '0;
    end else begin
      out_idx_o <= bit_cnt;
    end
  end
endmodule // spi_link_shifter

//--- rtl/spi_pin_role_and_select_logic.sv
// Pin roles, select handling and byte engines of the synchronous serial port.
// Notes on behaviour
// - Master-to-slave line is driven as master, input as slave.
// - Slave-to-master line is input as master, driven as a 3-wire or selected 4-wire slave.
// - Both lines carry each byte most significant bit first.
// - As master the outgoing line shows the shift register top bit.
// - Slave output floats when disabled or when an unselected 4-wire slave.
// - A 3-wire slave always drives its output with the slave_tx bit picked by the link bit index.
// - Master generates serial clock; slave takes it from the master.
// - An unselected 4-wire slave ignores the serial clock.
// - Select mode 00 is 3-wire, select unused, slave always selected.
// - Select mode 01 makes select an input; low selects the slave.
// - In mode 01 a falling select input disables the master function.
// - Select mode 1x drives select out at the low mode bit level.
// - Select pin is mapped in every mode except 3-wire forms.
// - Master data write fills transmit buffer, starts transfer if shifter empty.
// - Transfer-complete flag rises after each byte, both directions.
// - Mode fault clears master and port enables and sets its flag.
// - Slave counts clock edges; after eight bits sets flag, stores byte unless one is unread.
`timescale 1ns/10ps
`include "spi_port_cfg.svh"
module spi_pin_role_and_select_logic
  import spi_port_pkg::*;
#(
  parameter int BYTE_W   = `BYTE_BITS,
  parameter int SCK_HALF = `SCK_HALF_CYCLES
) (
  // Core clock and reset
  input  wire logic              CORE_CLK_I,
  input  wire logic              SYS_RST_I,
  // Control write
  input  wire logic              CTRL_WR_I,
  input  wire logic              MASTER_ENABLE_I,
  input  wire logic              PORT_ENABLE_I,
  input  wire logic [1:0]        SELECT_MODE_I,
  // Flag clears, one-cycle pulses
  input  wire logic              CLR_TRANSFER_COMPLETE_I,
  input  wire logic              CLR_MODE_FAULT_I,
  input  wire logic              CLR_WRITE_COLLISION_I,
  input  wire logic              CLR_RX_OVERRUN_I,
  // Data access
  input  wire logic              DATA_WR_I,
  input  wire logic [BYTE_W-1:0] DATA_I,
  input  wire logic              DATA_RD_I,
  output wire logic [BYTE_W-1:0] DATA_O,
  // Status
  output wire logic              MASTER_ENABLE_O,
  output wire logic              PORT_ENABLE_O,
  output wire logic [1:0]        SELECT_MODE_O,
  output wire logic              TRANSFER_COMPLETE_O,
  output wire logic              MODE_FAULT_O,
  output wire logic              WRITE_COLLISION_O,
  output wire logic              RX_OVERRUN_O,
  output wire logic              TX_BUFFER_FULL_O,
  output wire logic              BUSY_O,
  // Serial clock pin
  input  wire logic              SCK_I,
  output wire logic              SCK_O,
  output wire logic              SCK_OE_O,
  // Master-to-slave data pin
  input  wire logic              MOSI_I,
  output wire logic              MOSI_O,
  output wire logic              MOSI_OE_O,
  // Slave-to-master data pin
  input  wire logic              MISO_I,
  output wire logic              MISO_O,
  output wire logic              MISO_OE_O,
  // Slave select pin
  input  wire logic              SLAVE_SELECT_N_I,
  output wire logic              SLAVE_SELECT_N_O,
  output wire logic              SLAVE_SELECT_N_OE_O,
  output wire logic              SLAVE_SELECT_MAPPED_O
);
  localparam int CW = $clog2(BYTE_W);
  localparam int DW = $clog2(SCK_HALF + 1);

  // Bit index for most-significant-first order.
  function automatic logic [CW-1:0] msb_index(input logic [CW-1:0] pos);
    msb_index = CW'(BYTE_W - 1) - pos;
  endfunction

  // Control state.
  logic               master_enable_bit;
  logic               port_enable_bit;
  select_mode_t       select_mode_field;
  logic               select_mode_high_bit;
  logic               select_mode_low_bit;
  logic               transfer_complete_flag;
  logic               mode_fault_flag;
  logic               write_collision;
  logic               rx_overrun;
  // Data path.
  logic [BYTE_W-1:0]  tx_buf;
  logic               tx_full;
  logic [BYTE_W-1:0]  rx_buf;
  logic               rx_unread;
  logic [BYTE_W-1:0]  slave_tx;
  logic               slave_empty;
  // Master engine.
  master_state_t      state;
  logic [DW-1:0]      div;
  logic [CW-1:0]      bit_cnt;
  logic [BYTE_W-1:0]  mshift;
  logic               mbit;
  logic               sck_q;
  logic               m_done;
  logic               busy;
  // Pins and crossings.
  logic               mosi_oe;
  logic               miso_oe;
  logic               sck_oe;
  logic               nss_out;
  logic               nss_oe;
  logic               nss_mapped;
  logic               link_hold;
  logic               four_wire_in;
  logic               nss_prev;
  logic               done_prev;
  logic [`SYNC_COUNT-1:0] sync_in;
  logic [`SYNC_COUNT-1:0] sync_out;
  logic [BYTE_W-1:0]  link_rx;
  logic               link_tgl;
  logic [CW-1:0]      link_idx;
  logic               link_restart;

  wire master_run  = port_enable_bit & master_enable_bit;
  wire slave_run   = port_enable_bit & ~master_enable_bit;
  wire mode_3wire  = (select_mode_field == `SEL_THREE_WIRE);
  wire mode_4in    = (select_mode_field == `SEL_FOUR_WIRE_IN);
  wire nss_s       = sync_out[`SYNC_NSS];
  wire miso_s      = sync_out[`SYNC_MISO];
  wire done_s      = sync_out[`SYNC_DONE];
  wire tick        = (div == DW'(SCK_HALF - 1));
  wire m_load      = (state == M_IDLE) & master_run & tx_full;
  wire s_load      = slave_run & tx_full & slave_empty;
  wire s_done      = slave_run & (done_s ^ done_prev);
  wire mode_fault  = mode_4in & master_enable_bit & nss_prev & ~nss_s;

  assign select_mode_high_bit = select_mode_field[`SEL_OUT_BIT];
  assign select_mode_low_bit  = select_mode_field[`SEL_LEVEL_BIT];

  // Select and MISO pins pass two flip-flops before the core-clock logic reads them.
  assign sync_in[`SYNC_NSS]  = SLAVE_SELECT_N_I;
  assign sync_in[`SYNC_MISO] = MISO_I;
  assign sync_in[`SYNC_DONE] = link_tgl;

  spi_sync #(
    .WIDTH (`SYNC_COUNT)
  ) u_sync (
    .clk_i (CORE_CLK_I),
    .rst_i (SYS_RST_I),
    .d_i   (sync_in),
    .q_o   (sync_out)
  );

  // The select pin clears the slave bit count directly, so no clock is needed.
  assign link_restart = link_hold | (four_wire_in & SLAVE_SELECT_N_I);

  spi_link_shifter #(
    .WIDTH (BYTE_W)
  ) u_link (
    .sck_i      (SCK_I),
    .hold_i     (link_hold),
    .restart_i  (link_restart),
    .mosi_i     (MOSI_I),
    .rx_byte_o  (link_rx),
    .done_tgl_o (link_tgl),
    .out_idx_o  (link_idx)
  );

  // Control bits; a mode fault outranks a simultaneous software write.
  always_ff @(posedge CORE_CLK_I) begin
    if (SYS_RST_I) begin
      master_enable_bit <= `MASTER_EN_RESET;
      port_enable_bit   <= `PORT_EN_RESET;
      select_mode_field <= `SEL_MODE_RESET;
    end else if (mode_fault) begin
      master_enable_bit <= 1'h0;
      port_enable_bit   <= 1'h0;
    end else if (CTRL_WR_I) begin
      master_enable_bit <= MASTER_ENABLE_I;
      port_enable_bit   <= PORT_ENABLE_I;
      select_mode_field <= SELECT_MODE_I;
    end
  end

  // Sticky flags: a set in the same cycle as a clear wins.
  always_ff @(posedge CORE_CLK_I) begin
    if (SYS_RST_I) begin
      transfer_complete_flag <= 1'h0;
      mode_fault_flag        <= 1'h0;
      write_collision        <= 1'h0;
      rx_overrun             <= 1'h0;
    end else begin
      transfer_complete_flag <= m_done | s_done |
                                (transfer_complete_flag & ~CLR_TRANSFER_COMPLETE_I);
      mode_fault_flag        <= mode_fault | (mode_fault_flag & ~CLR_MODE_FAULT_I);
      write_collision        <= (DATA_WR_I & tx_full) |
                                (write_collision & ~CLR_WRITE_COLLISION_I);
      rx_overrun             <= (s_done & rx_unread & ~DATA_RD_I) |
                                (rx_overrun & ~CLR_RX_OVERRUN_I);
    end
  end

  // Transmit buffer; a write while it is still full is dropped.
  always_ff @(posedge CORE_CLK_I) begin
    if (SYS_RST_I) begin
      tx_buf  <= '0;
      tx_full <= 1'h0;
    end else if (DATA_WR_I && !tx_full) begin
      tx_buf  <= DATA_I;
      tx_full <= 1'h1;
    end else if (m_load || s_load) begin
      tx_full <= 1'h0;
    end
  end

  // Slave shift data; only reloaded between bytes, after the last clock edge.
  always_ff @(posedge CORE_CLK_I) begin
    if (SYS_RST_I) begin
      slave_tx    <= '0;
      slave_empty <= 1'h1;
    end else if (!slave_run) begin
      slave_empty <= 1'h1;
    end else if (s_load) begin
      slave_tx    <= tx_buf;
      slave_empty <= 1'h0;
    end else if (s_done) begin
      slave_empty <= 1'h1;
    end
  end

  // Receive buffer; as slave an unread byte is kept and the new one lost.
  always_ff @(posedge CORE_CLK_I) begin
    if (SYS_RST_I) begin
      rx_buf    <= '0;
      rx_unread <= 1'h0;
    end else if (m_done) begin
      rx_buf    <= mshift;
      rx_unread <= 1'h1;
    end else if (s_done && (!rx_unread || DATA_RD_I)) begin
      rx_buf    <= link_rx;
      rx_unread <= 1'h1;
    end else if (DATA_RD_I) begin
      rx_unread <= 1'h0;
    end
  end

  // Crossing history; toggles seen while the slave is idle are absorbed.
  always_ff @(posedge CORE_CLK_I) begin
    if (SYS_RST_I) begin
      nss_prev     <= 1'h1;
      done_prev    <= 1'h0;
      link_hold    <= 1'h1;
      four_wire_in <= 1'h0;
    end else begin
      nss_prev     <= nss_s;
      done_prev    <= done_s;
      link_hold    <= ~slave_run;
      four_wire_in <= mode_4in;
    end
  end

  // Master engine: clock low half, then high half, per bit.
  always_ff @(posedge CORE_CLK_I) begin
    if (SYS_RST_I) begin
      state   <= M_IDLE;
      div     <= '0;
      bit_cnt <= '0;
      mshift  <= '0;
      mbit    <= 1'h0;
      sck_q   <= 1'h0;
      m_done  <= 1'h0;
      busy    <= 1'h0;
    end else begin
      m_done <= 1'h0;
      unique case (state)
        M_IDLE: begin
          sck_q <= 1'h0;
          div   <= '0;
          if (m_load) begin
            mshift  <= tx_buf;
            bit_cnt <= '0;
            state   <= M_LOW;
            busy    <= 1'h1;
          end
        end
        M_LOW: begin
          if (!master_run) begin
            state <= M_IDLE;
            busy  <= 1'h0;
          end else if (tick) begin
            div   <= '0;
            sck_q <= 1'h1;
            mbit  <= miso_s;
            state <= M_HIGH;
          end else begin
            div <= div + DW'(1);
          end
        end
        M_HIGH: begin
          if (!master_run) begin
            sck_q <= 1'h0;
            state <= M_IDLE;
            busy  <= 1'h0;
          end else if (tick) begin
            div     <= '0;
            sck_q   <= 1'h0;
            mshift  <= {mshift[BYTE_W-2:0], mbit};
            bit_cnt <= bit_cnt + CW'(1);
            if (bit_cnt == CW'(BYTE_W - 1)) begin
              m_done <= 1'h1;
              state  <= M_IDLE;
              busy   <= 1'h0;
            end else begin
              state <= M_LOW;
            end
          end else begin
            div <= div + DW'(1);
          end
        end
      endcase
    end
  end

  // Pin roles from the enables and the select mode.
  always_ff @(posedge CORE_CLK_I) begin
    if (SYS_RST_I) begin
      mosi_oe    <= 1'h0;
      sck_oe     <= 1'h0;
      miso_oe    <= 1'h0;
      nss_out    <= 1'h1;
      nss_oe     <= 1'h0;
      nss_mapped <= 1'h1;
    end else begin
      mosi_oe    <= master_run;
      sck_oe     <= master_run;
      miso_oe    <= slave_run & (mode_3wire | (mode_4in & ~nss_s));
      nss_out    <= select_mode_low_bit;
      nss_oe     <= select_mode_high_bit;
      nss_mapped <= ~mode_3wire;
    end
  end

  assign DATA_O                = rx_buf;
  assign MASTER_ENABLE_O       = master_enable_bit;
  assign PORT_ENABLE_O         = port_enable_bit;
  assign SELECT_MODE_O         = select_mode_field;
  assign TRANSFER_COMPLETE_O   = transfer_complete_flag;
  assign MODE_FAULT_O          = mode_fault_flag;
  assign WRITE_COLLISION_O     = write_collision;
  assign RX_OVERRUN_O          = rx_overrun;
  assign TX_BUFFER_FULL_O      = tx_full;
  assign BUSY_O                = busy;
  assign SCK_O                 = sck_q;
  assign SCK_OE_O              = sck_oe;
  assign MOSI_O                = mshift[BYTE_W-1];
  assign MOSI_OE_O             = mosi_oe;
  // The slave bit is picked by index from slave_tx so the first bit is ready before any edge.
  assign MISO_O                = slave_tx[msb_index(link_idx)];
  assign MISO_OE_O             = miso_oe;
  assign SLAVE_SELECT_N_O      = nss_out;
  assign SLAVE_SELECT_N_OE_O   = nss_oe;
  assign SLAVE_SELECT_MAPPED_O = nss_mapped;
endmodule // spi_pin_role_and_select_logic

//--- tb/spi_port_properties.sv
// Concurrent checks on the pin roles and select handling of the serial port.
`timescale 1ns/10ps
module spi_port_properties (
  // Clock and reset
  input wire logic       CORE_CLK_I,
  input wire logic       SYS_RST_I,
  // Inputs
  input wire logic       DATA_WR_I,
  input wire logic       SLAVE_SELECT_N_I,
  // Outputs
  input wire logic       MASTER_ENABLE_O,
  input wire logic       PORT_ENABLE_O,
  input wire logic [1:0] SELECT_MODE_O,
  input wire logic       TRANSFER_COMPLETE_O,
  input wire logic       MODE_FAULT_O,
  input wire logic       TX_BUFFER_FULL_O,
  input wire logic       BUSY_O,
  input wire logic       MOSI_OE_O,
  input wire logic       MISO_OE_O,
  input wire logic       SLAVE_SELECT_N_O,
  input wire logic       SLAVE_SELECT_N_OE_O,
  input wire logic       SLAVE_SELECT_MAPPED_O
);
  default clocking @(posedge CORE_CLK_I);
  endclocking
  default disable iff (SYS_RST_I);

  // Pin enables trail the control bits by a register and the select pin by a
  // synchroniser, so each role check waits until its cause has held a while.
  logic [2:0] mst_h;
  logic [2:0] off_h;
  logic [2:0] tw_h;
  logic [5:0] uns_h;

  always_ff @(posedge CORE_CLK_I) begin
    mst_h <= {mst_h[1:0], MASTER_ENABLE_O & PORT_ENABLE_O};
    off_h <= {off_h[1:0], ~PORT_ENABLE_O};
    tw_h  <= {tw_h[1:0], PORT_ENABLE_O & ~MASTER_ENABLE_O & (SELECT_MODE_O == 2'h0)};
    uns_h <= {uns_h[4:0], ~MASTER_ENABLE_O & SLAVE_SELECT_N_I & (SELECT_MODE_O == 2'h1)};
  end

  chk_master_roles: assert property (mst_h == 3'h7 |-> MOSI_OE_O && !MISO_OE_O)
    else $error("Master pin roles wrong.");
  chk_slave_mosi_in: assert property (mst_h == 3'h0 |-> !MOSI_OE_O)
    else $error("Data out driven while not master.");
  chk_disabled_float: assert property (off_h == 3'h7 |-> !MISO_OE_O)
    else $error("Slave output driven while disabled.");
  chk_unselected_float: assert property (uns_h == 6'h3f |-> !MISO_OE_O)
    else $error("Unselected slave drives its output.");
  chk_clock_ignored: assert property (uns_h == 6'h3f |-> !$rose(TRANSFER_COMPLETE_O))
    else $error("Unselected slave completed a byte.");
  chk_three_wire_drive: assert property (tw_h == 3'h7 |-> MISO_OE_O)
    else $error("Three-wire slave output not driven.");
  chk_select_output: assert property (SELECT_MODE_O[1] && $stable(SELECT_MODE_O)
    |-> SLAVE_SELECT_N_OE_O && SLAVE_SELECT_N_O == SELECT_MODE_O[0])
    else $error("Select output wrong.");
  chk_select_mapped: assert property ($stable(SELECT_MODE_O)
    |-> SLAVE_SELECT_MAPPED_O == (SELECT_MODE_O != 2'h0))
    else $error("Select pin mapping wrong.");
  chk_fault_disable: assert property ($rose(MODE_FAULT_O)
    |-> !MASTER_ENABLE_O && !PORT_ENABLE_O)
    else $error("Mode fault left port enabled.");
  chk_fault_cause: assert property (SELECT_MODE_O == 2'h1 && mst_h[0] && MASTER_ENABLE_O
    && PORT_ENABLE_O && $fell(SLAVE_SELECT_N_I) |-> ##[1:5] MODE_FAULT_O)
    else $error("Falling select did not stop master.");
  chk_write_start: assert property (DATA_WR_I && !TX_BUFFER_FULL_O && !BUSY_O
    && mst_h == 3'h7 |=> TX_BUFFER_FULL_O ##1 BUSY_O && !TX_BUFFER_FULL_O)
    else $error("Write did not start a transfer.");
  chk_byte_complete: assert property ($fell(BUSY_O) && MASTER_ENABLE_O && PORT_ENABLE_O
    |-> ##[0:2] TRANSFER_COMPLETE_O)
    else $error("Byte end without complete flag.");
endmodule // spi_port_properties

//--- tb/spi_far_end.sv
// Far-end model: a slave that answers the port, and a master that clocks it.
`timescale 1ns/10ps
module spi_far_end (
  // Wires
  input  wire logic sck_i,
  input  wire logic mosi_i,
  input  wire logic miso_i,
  input  wire logic ss_n_i,
  // Drivers
  output logic      sck_o,
  output logic      mosi_o,
  output wire logic miso_o
);
  logic [7:0] sh = 8'h00;
  logic [7:0] rx = 8'h00;

  initial begin
    sck_o = 1'b0;
    mosi_o = 1'b0;
  end

  // A released line shows the inverse of its last bit, so stale data never matches.
  assign miso_o = ss_n_i ? ~sh[7] : sh[7];

  always @(posedge sck_i) if (!ss_n_i) rx <= {rx[6:0], mosi_i};
  always @(negedge sck_i) if (!ss_n_i) sh <= {sh[6:0], 1'b0};

  task automatic load(input logic [7:0] b);
    sh = b;
  endtask

  // The clock stands low outside a frame.
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rd);
    for (int i = 7; i >= 0; i--) begin
      mosi_o = tx[i];
      #15;
      sck_o = 1'b1;
      rd[i] = miso_i;
      #15;
      sck_o = 1'b0;
    end
    mosi_o = ~mosi_o;
  endtask
endmodule // spi_far_end

//--- tb/spi_pin_role_and_select_logic_tb_top.sv
// Self-checking bench for the serial port pin-role and select logic.
`timescale 1ns/10ps
module spi_pin_role_and_select_logic_tb_top;
  logic       clk, rst, cwr, mst, pen, dwr, drd, slave_select_n;
  logic [1:0] mode, md;
  logic [3:0] clr;
  logic [7:0] wdat, got;
  wire logic [7:0] rdat;
  wire logic [1:0] mode_o;
  wire logic  mst_o, pen_o, tc, mf, wc, ovr, full, busy, sck_o, sck_oe, mosi_o, mosi_oe;
  wire logic  miso_o, miso_oe, ss_o, ss_oe, mapped, far_sck, far_mosi, far_miso;
  int         mismatches = 0;
  int         tests_run = 0;
  // Each wire takes the level of whichever party enables its driver.
  wire logic  sck_w  = sck_oe ? sck_o : far_sck;
  wire logic  mosi_w = mosi_oe ? mosi_o : far_mosi;
  wire logic  miso_w = miso_oe ? miso_o : far_miso;
  wire logic  nss_w  = ss_oe ? ss_o : slave_select_n;

  spi_pin_role_and_select_logic i_spi_pin_role_and_select_logic (
    .CORE_CLK_I(clk), .SYS_RST_I(rst), .CTRL_WR_I(cwr), .MASTER_ENABLE_I(mst),
    .PORT_ENABLE_I(pen), .SELECT_MODE_I(mode), .CLR_TRANSFER_COMPLETE_I(clr[0]),
    .CLR_MODE_FAULT_I(clr[1]), .CLR_WRITE_COLLISION_I(clr[2]), .CLR_RX_OVERRUN_I(clr[3]),
    .DATA_WR_I(dwr), .DATA_I(wdat), .DATA_RD_I(drd), .DATA_O(rdat),
    .MASTER_ENABLE_O(mst_o), .PORT_ENABLE_O(pen_o), .SELECT_MODE_O(mode_o),
    .TRANSFER_COMPLETE_O(tc), .MODE_FAULT_O(mf), .WRITE_COLLISION_O(wc), .RX_OVERRUN_O(ovr),
    .TX_BUFFER_FULL_O(full), .BUSY_O(busy), .SCK_I(sck_w), .SCK_O(sck_o), .SCK_OE_O(sck_oe),
    .MOSI_I(mosi_w), .MOSI_O(mosi_o), .MOSI_OE_O(mosi_oe), .MISO_I(miso_w), .MISO_O(miso_o),
    .MISO_OE_O(miso_oe), .SLAVE_SELECT_N_I(nss_w), .SLAVE_SELECT_N_O(ss_o),
    .SLAVE_SELECT_N_OE_O(ss_oe), .SLAVE_SELECT_MAPPED_O(mapped)
  );

  spi_far_end i_spi_far_end (
    .sck_i(sck_w), .mosi_i(mosi_w), .miso_i(miso_w), .ss_n_i(nss_w),
    .sck_o(far_sck), .mosi_o(far_mosi), .miso_o(far_miso)
  );

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  task automatic tick();
    @(posedge clk);
    #1;
  endtask

  task automatic check(input logic [7:0] g, input logic [7:0] e, input string what);
    tests_run++;
    if (g !== e) begin
      mismatches++;
      $display("mismatch at %0t: %s got %h expected %h", $time, what, g, e);
    end
  endtask

  // Pins follow the control bits two edges after the write.
  task automatic ctrl(input logic m, input logic p, input logic [1:0] s);
    {mst, pen, mode} = {m, p, s};
    cwr = 1'b1;
    tick();
    cwr = 1'b0;
    repeat (2) tick();
  endtask

  task automatic wr(input logic [7:0] d);
    wdat = d;
    dwr = 1'b1;
    tick();
    dwr = 1'b0;
  endtask

  task automatic ack(input logic [4:0] v);
    {drd, clr} = v;
    tick();
    {drd, clr} = 5'h00;
  endtask

  task automatic wait_tc();
    for (int i = 0; i < 400 && tc !== 1'b1; i++) tick();
    if (tc !== 1'b1) begin
      mismatches++;
      $display("mismatch at %0t: transfer complete timed out", $time);
    end
  endtask

  task automatic end_sim();
    $display("Comparisons %0d, mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  initial begin
    #500000;
    mismatches++;
    end_sim();
  end

  initial begin
    {cwr, mst, pen, dwr, drd, clr, mode, wdat} = '0;
    rst = 1'b1;
    slave_select_n = 1'b1;
    repeat (10) tick();
    rst = 1'b0;
    tick();
    check({mf, tc, wc, mosi_oe, miso_oe, ss_oe, mapped, ss_o}, 8'h03, "reset pins");
    check({6'h00, mode_o}, 8'h01, "reset mode");
    for (int m = 0; m < 4; m++) begin
      md = 2'(m);
      ctrl(1'b1, 1'b1, md);
      check({2'h0, mode_o, mosi_oe, miso_oe, ss_oe, mapped},
            {2'h0, md, 2'h2, md[1], md != 2'h0}, "master pins");
      if (md[1]) check({7'h00, ss_o}, {7'h00, md[0]}, "select level");
    end
    ctrl(1'b1, 1'b1, 2'h2);
    i_spi_far_end.load(8'h96);
    wr(8'h3c);
    repeat (3) tick();
    check({5'h00, sck_oe, busy, full}, 8'h06, "busy after write");
    wr(8'h99);
    tick();
    wr(8'h77);
    tick();
    check({6'h00, full, wc}, 8'h03, "collision");
    wait_tc();
    check(rdat, 8'h96, "master rx");
    check(i_spi_far_end.rx, 8'h3c, "far rx");
    ack(5'h01);
    wait_tc();
    check(rdat, 8'h00, "second rx");
    check(i_spi_far_end.rx, 8'h99, "queued byte");
    ack(5'h15);
    ctrl(1'b0, 1'b1, 2'h1);
    slave_select_n = 1'b0;
    repeat (3) tick();
    wr(8'h81);
    tick();
    check({6'h00, sck_oe, miso_oe}, 8'h01, "selected slave drives");
    #7;
    i_spi_far_end.xfer(8'h5a, got);
    wait_tc();
    check(rdat, 8'h5a, "slave rx");
    check(got, 8'h81, "slave tx");
    ack(5'h11);
    slave_select_n = 1'b1;
    repeat (8) tick();
    check({7'h00, miso_oe}, 8'h00, "unselected float");
    i_spi_far_end.xfer(8'hff, got);
    repeat (8) tick();
    check({tc, rdat[6:0]}, 8'h5a, "clock ignored");
    ctrl(1'b0, 1'b1, 2'h0);
    check({6'h00, miso_oe, mapped}, 8'h02, "three-wire slave");
    i_spi_far_end.xfer(8'hc3, got);
    wait_tc();
    check(rdat, 8'hc3, "three-wire rx");
    check(got, 8'h81, "three-wire tx");
    ack(5'h01);
    i_spi_far_end.xfer(8'h24, got);
    wait_tc();
    check(rdat, 8'hc3, "overrun keeps byte");
    check({7'h00, ovr}, 8'h01, "overrun flag");
    ctrl(1'b0, 1'b0, 2'h0);
    check({7'h00, miso_oe}, 8'h00, "disabled float");
    ctrl(1'b1, 1'b1, 2'h1);
    slave_select_n = 1'b0;
    repeat (6) tick();
    check({5'h00, mf, mst_o, pen_o}, 8'h04, "mode fault");
    ack(5'h02);
    tick();
    check({7'h00, mf}, 8'h00, "fault cleared");
    end_sim();
  end
endmodule // spi_pin_role_and_select_logic_tb_top

bind spi_pin_role_and_select_logic spi_port_properties i_spi_port_properties (
  .CORE_CLK_I(CORE_CLK_I), .SYS_RST_I(SYS_RST_I), .DATA_WR_I(DATA_WR_I),
  .SLAVE_SELECT_N_I(SLAVE_SELECT_N_I), .MASTER_ENABLE_O(MASTER_ENABLE_O),
  .PORT_ENABLE_O(PORT_ENABLE_O), .SELECT_MODE_O(SELECT_MODE_O),
  .TRANSFER_COMPLETE_O(TRANSFER_COMPLETE_O), .MODE_FAULT_O(MODE_FAULT_O),
  .TX_BUFFER_FULL_O(TX_BUFFER_FULL_O), .BUSY_O(BUSY_O), .MOSI_OE_O(MOSI_OE_O),
  .MISO_OE_O(MISO_OE_O), .SLAVE_SELECT_N_O(SLAVE_SELECT_N_O),
  .SLAVE_SELECT_N_OE_O(SLAVE_SELECT_N_OE_O), .SLAVE_SELECT_MAPPED_O(SLAVE_SELECT_MAPPED_O)
);
